// File: include/usc_status_control_map.vh
// Register offsets, field positions, reset values and constants of the serial status and control block
`ifndef USC_STATUS_CONTROL_MAP_VH
`define USC_STATUS_CONTROL_MAP_VH

// Register offsets
`define USC_OFF_TX_LOW          4'h2
`define USC_OFF_TX_HIGH         4'h3
`define USC_OFF_STATUS          4'h4
`define USC_OFF_INT_CTRL        4'h5
`define USC_OFF_EN_CTRL         4'h6

// Reset values
`define USC_RST_STATUS          8'h00
`define USC_RST_INT_CTRL        8'h00
`define USC_RST_EN_CTRL         8'h00
`define USC_RST_TX_DATA         9'h000

// Status field positions
`define USC_ST_RXC              7
`define USC_ST_TXC              6
`define USC_ST_DRE              5
`define USC_ST_RXS              4
`define USC_ST_SYNC             3
`define USC_ST_BREAK            1
`define USC_ST_WAIT_BREAK       0

// Interrupt control field positions
`define USC_IC_RXC_IE           7
`define USC_IC_TXC_IE           6
`define USC_IC_DRE_IE           5
`define USC_IC_START_IE         4
`define USC_IC_LOOPBACK         3
`define USC_IC_ABAUD_IE         2
`define USC_IC_DRIVER_HI        1
`define USC_IC_DRIVER_LO        0

// Enable control field positions
`define USC_EC_RX_EN            7
`define USC_EC_TX_EN            6
`define USC_EC_START_DET        4
`define USC_EC_OPEN_DRAIN       3
`define USC_EC_MODE_HI          2
`define USC_EC_MODE_LO          1
`define USC_EC_MULTI_PROC       0
`define USC_EC_WRITE_MASK       8'hDF

// Transmit high byte ninth bit position
`define USC_TX_NINTH            0

// Line driver modes
`define USC_DRV_OFF             2'h0
`define USC_DRV_EXTERNAL        2'h1
`define USC_DRV_INTERNAL        2'h2

// Receive modes
`define USC_RXM_GENERIC_AUTO    2'h2
`define USC_RXM_LIN_AUTO        2'h3

// Character sizes with nine data bits
`define USC_CHS_NINE_LOW_FIRST  3'h6
`define USC_CHS_NINE_HIGH_FIRST 3'h7

// Auto-baud constants
`define USC_SYNC_CHAR           8'h55
`define USC_BREAK_BITS          4'hB

`endif

// File: core/usc_status_control.v
// Status flags, interrupt enables and enable control of the serial port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "usc_status_control_map.vh"

// How it works
// (RULE1) Ninth transmit bit only in nine-bit size
// (RULE2) Receive flag follows buffer; disable flushes it
// (RULE3) Transmit done when frame out, buffer empty
// (RULE4) Buffer empty until low byte written
// (RULE5) Software writes zero to buffer empty bit
// (RULE6) Start flag on falling edge in standby
// (RULE7) Sync error on bad timing or char
// (RULE8) Break after eleven low bits plus sync
// (RULE9) Wait-for-break arms next low-high; reads zero
// (RULE10) Receive enable requests receive vector
// (RULE11) Transmit enable requests transmit vector
// (RULE12) Empty enable requests empty vector
// (RULE13) Start interrupt raised on receive vector
// (RULE14) Loop-back routes transmit line to receive
// (RULE15) Sync error interrupt on receive vector
// (RULE16) Line driver mode off, external, internal
// (RULE17) Receiver enable owns pin; clear flushes
// (RULE18) Transmitter disable waits for empty, releases pin
// (RULE19) Start detect wakes system from sleep
// (RULE20) Receive handler reads data to clear
// (RULE21) Transmit handler loads data or masks
// (RULE22) Auto-baud flags only in auto-baud modes
// (RULE23) Writing zero leaves clearable flags alone
module usc_status_control
(
   input  wire       clk,
   input  wire       rstn,
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire [2:0] character_size,
   input  wire       master_spi_mode,
   input  wire       sleep_idle,
   input  wire       sleep_standby,
   input  wire       bit_tick,
   input  wire       rx_buf_nonempty,
   input  wire       rx_char_done,
   input  wire       sync_char_valid,
   input  wire [7:0] sync_char,
   input  wire       sync_bad_timing,
   input  wire       tx_load,
   input  wire       tx_shift_done,
   input  wire       tx_busy,
   input  wire       tx_line,
   input  wire       transmit_vector_ack,
   output reg  [8:0] tx_buf_data,
   output wire       tx_buf_valid,
   output wire       receive_vector,
   output wire       transmit_vector,
   output wire       buffer_empty_vector,
   output reg        rx_flush,
   output reg        autobaud_restart,
   output reg        break_detected,
   output wire [1:0] receive_mode,
   output wire       double_speed_mode,
   output wire       multi_proc_mode,
   output wire       receiver_enable,
   output reg        rx_pin_owned,
   output wire       rx_line,
   input  wire       rxd_pin,
   output reg        txd_out,
   output reg        txd_oe_n,
   output reg        driver_enable_pin,
   output reg        wake_request
);

   reg  [7:0] int_ctrl_reg;
   reg  [7:0] en_ctrl_reg;
   reg        transmit_complete_flag_reg;
   reg        buffer_empty_flag_reg;
   reg        receive_start_flag_reg;
   reg        sync_error_flag_reg;
   reg        break_found_flag_reg;
   reg        wait_break_reg;
   reg        wait_low_seen_reg;
   reg        break_seen_reg;
   reg  [3:0] low_bits_reg;
   reg        rxd_meta_reg;
   reg        rxd_sync_reg;
   reg        rx_line_prev_reg;
   reg        tx_active_reg;
   reg  [7:0] rdata_next;
   reg        tx_ninth_reg;

   wire       receive_complete_flag;
   wire       receive_complete_irq_en;
   wire       transmit_complete_irq_en;
   wire       buffer_empty_irq_en;
   wire       start_frame_irq_en;
   wire       loopback_enable;
   wire       autobaud_error_irq_en;
   wire [1:0] line_driver_mode;
   wire       transmitter_enable;
   wire       start_frame_detect_enable;
   wire       open_drain_enable;
   wire       autobaud_mode;
   wire       wr_status;
   wire       wr_int_ctrl;
   wire       wr_en_ctrl;
   wire       wr_tx_low;
   wire       wr_tx_high;
   wire       rx_fall;
   wire       rx_rise;
   wire       start_event;
   wire       sync_fault;
   wire       sync_good;
   wire       wait_break_done;
   wire       rx_disable;
   wire       tx_drive;

   // Decodes the receive mode field into the auto-baud class
   function is_autobaud;
      input [1:0] mode;
      begin
         is_autobaud = (mode == `USC_RXM_GENERIC_AUTO) || (mode == `USC_RXM_LIN_AUTO);
      end
   endfunction

   // Decodes the character size into the nine-bit class
   function is_nine_bit;
      input [2:0] size;
      begin
         is_nine_bit = (size == `USC_CHS_NINE_LOW_FIRST) || (size == `USC_CHS_NINE_HIGH_FIRST);
      end
   endfunction

   assign receive_complete_irq_en   = int_ctrl_reg[`USC_IC_RXC_IE];
   assign transmit_complete_irq_en  = int_ctrl_reg[`USC_IC_TXC_IE];
   assign buffer_empty_irq_en       = int_ctrl_reg[`USC_IC_DRE_IE];
   assign start_frame_irq_en        = int_ctrl_reg[`USC_IC_START_IE];
   assign loopback_enable           = int_ctrl_reg[`USC_IC_LOOPBACK];
   assign autobaud_error_irq_en     = int_ctrl_reg[`USC_IC_ABAUD_IE];
   assign line_driver_mode          = int_ctrl_reg[`USC_IC_DRIVER_HI:`USC_IC_DRIVER_LO];
   assign receiver_enable           = en_ctrl_reg[`USC_EC_RX_EN];
   assign transmitter_enable        = en_ctrl_reg[`USC_EC_TX_EN];
   assign start_frame_detect_enable = en_ctrl_reg[`USC_EC_START_DET];
   assign open_drain_enable         = en_ctrl_reg[`USC_EC_OPEN_DRAIN];
   assign receive_mode              = en_ctrl_reg[`USC_EC_MODE_HI:`USC_EC_MODE_LO];
   assign multi_proc_mode           = en_ctrl_reg[`USC_EC_MULTI_PROC];
   assign double_speed_mode         = (receive_mode == 2'h1);
   assign autobaud_mode             = is_autobaud(receive_mode); // RULE22

   assign wr_status   = reg_wr && (reg_addr == `USC_OFF_STATUS);
   assign wr_int_ctrl = reg_wr && (reg_addr == `USC_OFF_INT_CTRL);
   assign wr_en_ctrl  = reg_wr && (reg_addr == `USC_OFF_EN_CTRL);
   assign wr_tx_low   = reg_wr && (reg_addr == `USC_OFF_TX_LOW);
   assign wr_tx_high  = reg_wr && (reg_addr == `USC_OFF_TX_HIGH);

   // Pin is synchronised before anything looks at it; loop-back bypasses the pin
   assign rx_line     = loopback_enable ? tx_line : rxd_sync_reg; // RULE14
   assign rx_fall     = rx_line_prev_reg && !rx_line;
   assign rx_rise     = !rx_line_prev_reg && rx_line;

   // Flag gated by the enable so that disabling reads as an empty buffer at once
   assign receive_complete_flag = rx_buf_nonempty && receiver_enable; // RULE2
   assign rx_disable  = wr_en_ctrl && receiver_enable && !reg_wdata[`USC_EC_RX_EN];

   assign start_event = start_frame_detect_enable && sleep_standby && !master_spi_mode && rx_fall; // RULE6

   assign sync_fault  = autobaud_mode && receiver_enable
                        && (sync_bad_timing
                            || (sync_char_valid && (receive_mode == `USC_RXM_LIN_AUTO)
                                && (sync_char != `USC_SYNC_CHAR))); // RULE7
   assign sync_good   = autobaud_mode && receiver_enable && sync_char_valid && !sync_fault;
   assign wait_break_done = wait_break_reg && wait_low_seen_reg && rx_rise; // RULE9

   assign tx_buf_valid = !buffer_empty_flag_reg;

   // Vector requests are levels that hold while flag and enable are both set
   assign receive_vector      = (receive_complete_flag && receive_complete_irq_en)     // RULE10 RULE20
                                || (receive_start_flag_reg && start_frame_irq_en)       // RULE13
                                || (sync_error_flag_reg && autobaud_error_irq_en);      // RULE15
   assign transmit_vector     = transmit_complete_flag_reg && transmit_complete_irq_en; // RULE11
   assign buffer_empty_vector = buffer_empty_flag_reg && buffer_empty_irq_en;          // RULE12 RULE21

   always @(posedge clk)
   begin
      if (!rstn)
      begin
         rxd_meta_reg     <= 1'b1;
         rxd_sync_reg     <= 1'b1;
         rx_line_prev_reg <= 1'b1;
      end
      else
      begin
         rxd_meta_reg     <= rxd_pin;
         rxd_sync_reg     <= rxd_meta_reg;
         rx_line_prev_reg <= rx_line;
      end
   end

   // Control registers
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         int_ctrl_reg <= `USC_RST_INT_CTRL;
         en_ctrl_reg  <= `USC_RST_EN_CTRL;
      end
      else
      begin
         if (wr_int_ctrl)
            int_ctrl_reg <= reg_wdata;
         if (wr_en_ctrl)
            en_ctrl_reg <= reg_wdata & `USC_EC_WRITE_MASK;
      end
   end

   // Transmit buffer; a low-byte write while it is still full is dropped
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         buffer_empty_flag_reg <= 1'b1;
         tx_buf_data           <= `USC_RST_TX_DATA;
         tx_ninth_reg          <= 1'b0;
      end
      else
      begin
         if (wr_tx_high)
            tx_ninth_reg <= reg_wdata[`USC_TX_NINTH];
         if (wr_tx_low && buffer_empty_flag_reg)
         begin
            buffer_empty_flag_reg <= 1'b0; // RULE4
            tx_buf_data[7:0]      <= reg_wdata;
            tx_buf_data[8]        <= is_nine_bit(character_size) && tx_ninth_reg; // RULE1
         end
         else if (tx_load)
            buffer_empty_flag_reg <= 1'b1; // RULE4
         // Late ninth bit for low-byte-first order while the word waits
         if (wr_tx_high && !buffer_empty_flag_reg && !tx_load)
            tx_buf_data[8] <= is_nine_bit(character_size) && reg_wdata[`USC_TX_NINTH]; // RULE1
      end
   end

   // Write-one-to-clear flags; a set in the same cycle wins over the clear
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         transmit_complete_flag_reg <= 1'b0;
         receive_start_flag_reg     <= 1'b0;
         sync_error_flag_reg        <= 1'b0;
         break_found_flag_reg       <= 1'b0;
      end
      else
      begin
         if (tx_shift_done && buffer_empty_flag_reg && !tx_load)
            transmit_complete_flag_reg <= 1'b1; // RULE3
         else if (transmit_vector_ack || (wr_status && reg_wdata[`USC_ST_TXC]))
            transmit_complete_flag_reg <= 1'b0; // RULE3 RULE23

         if (start_event)
            receive_start_flag_reg <= 1'b1; // RULE6
         else if (wr_status && reg_wdata[`USC_ST_RXS])
            receive_start_flag_reg <= 1'b0; // RULE23

         if (sync_fault)
            sync_error_flag_reg <= 1'b1; // RULE7
         else if ((wr_status && reg_wdata[`USC_ST_SYNC]) || rx_disable)
            sync_error_flag_reg <= 1'b0; // RULE23

         if (sync_good && break_seen_reg)
            break_found_flag_reg <= 1'b1; // RULE8
         else if (rx_char_done || (wr_status && reg_wdata[`USC_ST_BREAK]) || rx_disable)
            break_found_flag_reg <= 1'b0; // RULE8 RULE23
      end
   end

   // Break detector: eleven low bit times, or one low-high pair when armed
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         low_bits_reg      <= 4'h0;
         break_seen_reg    <= 1'b0;
         wait_break_reg    <= 1'b0;
         wait_low_seen_reg <= 1'b0;
         break_detected    <= 1'b0;
      end
      else if (rx_disable || !autobaud_mode)
      begin
         low_bits_reg      <= 4'h0; // RULE17
         break_seen_reg    <= 1'b0;
         wait_break_reg    <= wr_status && reg_wdata[`USC_ST_WAIT_BREAK] && autobaud_mode;
         wait_low_seen_reg <= 1'b0;
         break_detected    <= 1'b0;
      end
      else
      begin
         break_detected <= 1'b0;
         if (rx_line)
            low_bits_reg <= 4'h0;
         else if (bit_tick && (low_bits_reg != `USC_BREAK_BITS))
            low_bits_reg <= low_bits_reg + 4'h1;

         if (wr_status && reg_wdata[`USC_ST_WAIT_BREAK])
         begin
            wait_break_reg    <= 1'b1; // RULE9
            wait_low_seen_reg <= 1'b0;
         end
         else if (wait_break_done)
         begin
            wait_break_reg    <= 1'b0;
            wait_low_seen_reg <= 1'b0;
         end
         else if (wait_break_reg && rx_fall)
            wait_low_seen_reg <= 1'b1; // RULE9

         if ((bit_tick && !rx_line && (low_bits_reg == `USC_BREAK_BITS - 4'h1)) || wait_break_done)
         begin
            break_seen_reg <= 1'b1; // RULE8 RULE9
            break_detected <= 1'b1;
         end
         else if (sync_char_valid || sync_bad_timing || (wr_status && reg_wdata[`USC_ST_SYNC]))
            break_seen_reg <= 1'b0;
      end
   end

   // Pulses to the receive engine: flush on disable, back to idle on sync clear
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         rx_flush         <= 1'b0;
         autobaud_restart <= 1'b0;
         rx_pin_owned     <= 1'b0;
         wake_request     <= 1'b0;
      end
      else
      begin
         rx_flush         <= rx_disable; // RULE17
         autobaud_restart <= (wr_status && reg_wdata[`USC_ST_SYNC]) || (rx_disable && autobaud_mode); // RULE7 RULE17
         rx_pin_owned     <= receiver_enable; // RULE17
         wake_request     <= start_frame_detect_enable && (sleep_idle || sleep_standby) && rx_fall; // RULE19
      end
   end

   // Transmitter keeps the pin until both shift register and buffer drain; in internal driver mode it drives only while tx_busy
   assign tx_drive = tx_active_reg && ((line_driver_mode != `USC_DRV_INTERNAL) || tx_busy); // RULE16

   always @(posedge clk)
   begin
      if (!rstn)
      begin
         tx_active_reg     <= 1'b0;
         txd_out           <= 1'b1;
         txd_oe_n          <= 1'b1;
         driver_enable_pin <= 1'b0;
      end
      else
      begin
         tx_active_reg     <= transmitter_enable || (tx_active_reg && (tx_busy || !buffer_empty_flag_reg)); // RULE18
         txd_out           <= tx_line;
         // Open drain only pulls low; the high level comes from the pull-up
         txd_oe_n          <= !(tx_drive && !(open_drain_enable && tx_line)); // RULE18
         driver_enable_pin <= (line_driver_mode == `USC_DRV_EXTERNAL) && tx_active_reg && tx_busy; // RULE16
      end
   end

   // Read port: data stands the cycle after the strobe, unmapped reads zero
   always @*
   begin
      rdata_next = 8'h00;
      case (reg_addr)
         `USC_OFF_TX_LOW:   rdata_next = tx_buf_data[7:0];
         `USC_OFF_TX_HIGH:  rdata_next = {7'h00, tx_ninth_reg};
         `USC_OFF_STATUS:
         begin
            rdata_next[`USC_ST_RXC]   = receive_complete_flag;
            rdata_next[`USC_ST_TXC]   = transmit_complete_flag_reg;
            rdata_next[`USC_ST_DRE]   = buffer_empty_flag_reg; // RULE5
            rdata_next[`USC_ST_RXS]   = receive_start_flag_reg && start_frame_detect_enable; // RULE6
            rdata_next[`USC_ST_SYNC]  = sync_error_flag_reg;
            rdata_next[`USC_ST_BREAK] = break_found_flag_reg && autobaud_mode; // RULE8
         end
         `USC_OFF_INT_CTRL: rdata_next = int_ctrl_reg;
         `USC_OFF_EN_CTRL:  rdata_next = en_ctrl_reg;
         default:           rdata_next = 8'h00;
      endcase
   end

   always @(posedge clk)
   begin
      if (!rstn)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_next;
      else
         reg_rdata <= 8'h00;
   end

endmodule

// File: tb/usc_status_control_asserts.sv
// Port-level checks of the serial status and control block
`timescale 1ns/1ps
`include "usc_status_control_map.vh"
module usc_status_control_asserts
(
   input wire       clk,
   input wire       rstn,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire [2:0] character_size,
   input wire       tx_load,
   input wire       tx_shift_done,
   input wire       tx_busy,
   input wire       tx_line,
   input wire       transmit_vector_ack,
   input wire [8:0] tx_buf_data,
   input wire       tx_buf_valid,
   input wire       rx_buf_nonempty,
   input wire       receive_vector,
   input wire       transmit_vector,
   input wire       buffer_empty_vector,
   input wire       rx_flush,
   input wire       receiver_enable,
   input wire       rx_line,
   input wire       txd_oe_n,
   input wire       driver_enable_pin
);
   // Shadow of written controls; registers are not ports here
   logic [7:0] ic_sh;
   logic       transmitter_enable_sh;
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         ic_sh   <= 8'h00;
         transmitter_enable_sh <= 1'b0;
      end
      else if (reg_wr && reg_addr == `USC_OFF_INT_CTRL)
         ic_sh <= reg_wdata;
      else if (reg_wr && reg_addr == `USC_OFF_EN_CTRL)
         transmitter_enable_sh <= reg_wdata[`USC_EC_TX_EN];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_accept;
      reg_wr && reg_addr == `USC_OFF_TX_LOW && !tx_buf_valid && !tx_load;
   endsequence
   sequence s_rx_off;
      reg_wr && reg_addr == `USC_OFF_EN_CTRL && !reg_wdata[`USC_EC_RX_EN] && receiver_enable;
   endsequence
   sequence s_tx_idle;
      !transmitter_enable_sh && !tx_busy && !tx_buf_valid;
   endsequence
   ninth_bit_a: assert property ($rose(tx_buf_valid) && character_size[2:1] != 2'b11 && $stable(character_size)
      |-> !tx_buf_data[8]) else $error("ninth bit kept outside nine-bit size");
   empty_vector_a: assert property (buffer_empty_vector == (ic_sh[`USC_IC_DRE_IE] && !tx_buf_valid))
      else $error("buffer empty vector wrong");
   tx_accept_a: assert property (s_accept |=> tx_buf_valid)
      else $error("low byte write not taken");
   tx_drain_a: assert property (tx_buf_valid && tx_load |=> !tx_buf_valid)
      else $error("buffer still full after load");
   rx_vector_a: assert property (ic_sh[7] && receiver_enable && rx_buf_nonempty && $past(rx_buf_nonempty)
      |-> receive_vector) else $error("receive vector missing");
   tx_ack_clear_a: assert property (transmit_vector_ack && !tx_shift_done |=> !transmit_vector)
      else $error("transmit flag kept after ack");
   rx_off_flush_a: assert property (s_rx_off |-> ##[1:2] rx_flush)
      else $error("no flush on receiver disable");
   loop_back_a: assert property (ic_sh[`USC_IC_LOOPBACK] |-> rx_line == tx_line)
      else $error("loop-back path broken");
   driver_pin_a: assert property (ic_sh[1:0] != `USC_DRV_EXTERNAL |=> !driver_enable_pin)
      else $error("driver pin outside external mode");
   tx_release_a: assert property (s_tx_idle [*3] |-> txd_oe_n)
      else $error("transmit pin not released");
endmodule
bind usc_status_control usc_status_control_asserts chk_u
(
   .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .character_size, .tx_load, .tx_shift_done,
   .tx_busy, .tx_line, .transmit_vector_ack, .tx_buf_data, .tx_buf_valid, .rx_buf_nonempty,
   .receive_vector, .transmit_vector, .buffer_empty_vector, .rx_flush, .receiver_enable,
   .rx_line, .txd_oe_n, .driver_enable_pin
);

// File: tb/usc_remote_peer.sv
// Remote serial peer: drives the receive pin, sees the resolved transmit wire
`timescale 1ns/1ps
module usc_remote_peer
(
   input  wire  clk,
   input  wire  txd_out,
   input  wire  txd_oe_n,
   output logic rxd_pin,
   output wire  line_tx
);
   // Pull-up on the wire, so a released pin reads idle high
   assign line_tx = txd_oe_n ? 1'b1 : txd_out;
   initial rxd_pin = 1'b1;
   task automatic set_level(input logic v);
      @(posedge clk);
      rxd_pin <= v;
   endtask
endmodule

// File: tb/test_usart_status_control.sv
// Self-checking bench for the serial status and control block
`timescale 1ns/1ps
`include "usc_status_control_map.vh"
module test_usart_status_control;
   localparam [3:0] TL = `USC_OFF_TX_LOW, TH = `USC_OFF_TX_HIGH, ST = `USC_OFF_STATUS;
   localparam [3:0] IC = `USC_OFF_INT_CTRL, EC = `USC_OFF_EN_CTRL;
   // Pulse inputs by index: tick, char, sync, bad timing, load, done, ack
   localparam TK = 0, CH = 1, SY = 2, BT = 3, LD = 4, DN = 5, AK = 6;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0, reg_rd = 1'b0;
   logic [2:0] character_size = 3'h3;
   logic       sleep_standby = 1'b0, rx_buf_nonempty = 1'b0;
   logic [7:0] sync_char = 8'h00;
   logic       tx_busy = 1'b0, tx_line = 1'b1;
   logic [6:0] pul = 7'h00;
   wire  [7:0] reg_rdata;
   wire  [8:0] tx_buf_data;
   wire        tx_buf_valid, receive_vector, transmit_vector, buffer_empty_vector;
   wire        rx_flush, autobaud_restart, break_detected, receiver_enable, rx_line, rx_pin_owned;
   wire        txd_out, txd_oe_n, driver_enable_pin, wake_request, rxd_pin, line_tx;
   int         n_errors = 0, n_checks = 0;
   int         n_flush = 0, n_abr = 0, n_brk = 0, n_wake = 0, m;
   usc_status_control dut_u
   (
      .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .character_size,
      .master_spi_mode(1'b0), .sleep_idle(1'b0), .sleep_standby, .bit_tick(pul[TK]), .rx_buf_nonempty,
      .rx_char_done(pul[CH]), .sync_char_valid(pul[SY]), .sync_char, .sync_bad_timing(pul[BT]),
      .tx_load(pul[LD]), .tx_shift_done(pul[DN]), .tx_busy, .tx_line, .transmit_vector_ack(pul[AK]),
      .tx_buf_data, .tx_buf_valid, .receive_vector, .transmit_vector, .buffer_empty_vector, .rx_flush,
      .autobaud_restart, .break_detected, .receive_mode(), .double_speed_mode(), .multi_proc_mode(),
      .receiver_enable, .rx_pin_owned, .rx_line, .rxd_pin, .txd_out, .txd_oe_n, .driver_enable_pin,
      .wake_request
   );
   usc_remote_peer peer_u (.clk, .txd_out, .txd_oe_n, .rxd_pin, .line_tx);
   always #5 clk = ~clk;
   // Pulses are counted for scenarios to look at later
   always @(posedge clk)
   begin
      n_flush <= n_flush + rx_flush;
      n_abr <= n_abr + autobaud_restart;
      n_brk <= n_brk + break_detected;
      n_wake <= n_wake + wake_request;
   end
   task automatic chk(string nm, logic [8:0] seen, logic [8:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdc(string nm, logic [3:0] a, logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, reg_rdata, exp);
   endtask
   task automatic pulse(int i);
      @(posedge clk);
      pul[i] <= 1'b1;
      @(posedge clk);
      pul[i] <= 1'b0;
      #1;
   endtask
   task automatic wait_cy(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_regs();
      rdc("status", ST, 8'h20);
      rdc("irq ctrl", IC, 8'h00);
      rdc("en ctrl", EC, 8'h00);
      wr(4'hF, 8'hFF);
      rdc("unmapped", 4'hF, 8'h00);
      wr(IC, 8'hFC);
      rdc("irq ctrl", IC, 8'hFC);
      wr(IC, 8'h00);
      wr(EC, 8'hFF);
      rdc("en ctrl", EC, 8'hDF);
      m = n_flush;
      wr(EC, 8'h00);
      wait_cy(3);
      chk("flush", 9'(n_flush - m), 9'h001);
   endtask
   task automatic t_tx();
      wr(IC, 8'h60);
      chk("empty vec", buffer_empty_vector, 9'h001);
      wr(TH, 8'h01);
      wr(TL, 8'h41);
      chk("tx word", tx_buf_data, 9'h041);
      chk("empty vec", buffer_empty_vector, 9'h000);
      wr(TL, 8'h99);
      chk("tx word", tx_buf_data, 9'h041);
      pulse(LD);
      chk("empty vec", buffer_empty_vector, 9'h001);
      @(posedge clk) character_size <= 3'h7;
      wr(TH, 8'h01);
      wr(TL, 8'h42);
      chk("tx word", tx_buf_data, 9'h142);
      pulse(LD);
      pulse(DN);
      rdc("status", ST, 8'h60);
      chk("tx vec", transmit_vector, 9'h001);
      wr(ST, 8'h00);
      chk("tx vec", transmit_vector, 9'h001);
      wr(ST, 8'h40);
      chk("tx vec", transmit_vector, 9'h000);
      pulse(DN);
      pulse(AK);
      chk("tx vec", transmit_vector, 9'h000);
      @(posedge clk) character_size <= 3'h3;
   endtask
   task automatic t_rx();
      wr(IC, 8'h80);
      wr(EC, 8'h80);
      @(posedge clk) rx_buf_nonempty <= 1'b1;
      wait_cy(2);
      chk("rx vec", receive_vector, 9'h001);
      chk("owned", rx_pin_owned, 9'h001);
      rdc("status", ST, 8'hA0);
      wr(EC, 8'h00);
      rdc("status", ST, 8'h20);
      @(posedge clk) rx_buf_nonempty <= 1'b0;
   endtask
   task automatic t_sync();
      wr(IC, 8'h04);
      wr(EC, 8'h86);
      @(posedge clk) sync_char <= 8'h54;
      pulse(SY);
      rdc("status", ST, 8'h28);
      chk("rx vec", receive_vector, 9'h001);
      m = n_abr;
      wr(ST, 8'h08);
      wait_cy(2);
      chk("restart", 9'(n_abr - m), 9'h001);
      wr(EC, 8'h84);
      pulse(SY);
      rdc("status", ST, 8'h20);
      pulse(BT);
      rdc("status", ST, 8'h28);
      wr(ST, 8'h08);
      wr(EC, 8'h80);
      pulse(BT);
      rdc("status", ST, 8'h20);
   endtask
   task automatic t_break();
      wr(EC, 8'h86);
      peer_u.set_level(1'b0);
      wait_cy(3);
      m = n_brk;
      repeat (10) pulse(TK);
      chk("break", 9'(n_brk - m), 9'h000);
      pulse(TK);
      wait_cy(2);
      chk("break", 9'(n_brk - m), 9'h001);
      peer_u.set_level(1'b1);
      @(posedge clk) sync_char <= 8'h55;
      pulse(SY);
      rdc("status", ST, 8'h22);
      pulse(CH);
      rdc("status", ST, 8'h20);
   endtask
   task automatic t_start();
      wr(IC, 8'h10);
      wr(EC, 8'h90);
      @(posedge clk) sleep_standby <= 1'b1;
      m = n_wake;
      peer_u.set_level(1'b0);
      wait_cy(5);
      chk("wake", 9'(n_wake - m), 9'h001);
      chk("rx vec", receive_vector, 9'h001);
      rdc("status", ST, 8'h30);
      peer_u.set_level(1'b1);
      wr(ST, 8'h11);
      rdc("status", ST, 8'h20);
      @(posedge clk) sleep_standby <= 1'b0;
   endtask
   task automatic t_pins();
      wr(IC, 8'h09);
      wr(EC, 8'h40);
      @(posedge clk) tx_line <= 1'b0;
      tx_busy <= 1'b1;
      wait_cy(3);
      chk("loop", rx_line, 9'h000);
      chk("driver", driver_enable_pin, 9'h001);
      chk("wire", line_tx, 9'h000);
      wr(EC, 8'h00);
      chk("oe", txd_oe_n, 9'h000);
      @(posedge clk) tx_busy <= 1'b0;
      tx_line <= 1'b1;
      wait_cy(3);
      chk("oe", txd_oe_n, 9'h001);
      chk("driver", driver_enable_pin, 9'h000);
      wr(IC, 8'h02);
      wr(EC, 8'h40);
      wait_cy(3);
      chk("oe", txd_oe_n, 9'h001);
      @(posedge clk) tx_busy <= 1'b1;
      wait_cy(3);
      chk("oe", txd_oe_n, 9'h000);
      chk("driver", driver_enable_pin, 9'h000);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_tx();
      t_rx();
      t_sync();
      t_break();
      t_start();
      t_pins();
      finish_test();
   end
   // Scenarios need under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      finish_test();
   end
endmodule
